// File: inc/acs_pkg.sv
// constants and types shared by the conversion sequencer
package acs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CLKDIV = 8'h04;
   localparam logic [7:0] ADDR_TRIG   = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0C;
   localparam logic [7:0] ADDR_PREV   = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_ACC    = 8'h18;
   localparam logic [7:0] ADDR_ERR    = 8'h1C;
   localparam logic [7:0] ADDR_SETPT  = 8'h20;
   localparam logic [7:0] ADDR_THRESH = 8'h24;
   // control register fields
   localparam int CTRL_GO   = 0;
   localparam int CTRL_ON   = 1;
   localparam int CTRL_CS   = 2;
   localparam int CTRL_JUST   = 3;
   localparam int CTRL_REPEAT = 4;
   localparam int CTRL_PREV   = 5;
   localparam int CTRL_DOUBLE = 6;
   localparam int CTRL_IE   = 7;
   // status register fields
   localparam int STAT_DONE = 0;
   localparam int STAT_THR  = 1;
   localparam int STAT_COMPUTATION_STATUS_BIT = 2;
   // widths and reset values
   localparam int RES_W  = 12;
   localparam int ACC_W  = 16;
   localparam int DIV_W  = 7;
   localparam int TRG_W  = 3;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [11:0] RES_RST = 12'h000;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // timing: one instruction cycle of extra start delay with the rc clock
   localparam int CLK_NS     = 50;
   localparam int T_INSTR_NS = 200;
   localparam int INSTR_CYC  = (T_INSTR_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_CONV = 2'h3,
      ST_CALC = 2'h2
   } acs_state_type;
endpackage : acs_pkg

// File: src/acs_sequencer.sv
// control and sequencing logic of a 12-bit successive-approximation converter
// Operation
// - done flag sets at every conversion end regardless of interrupt enable
// - enabled interrupt in sleep raises request and wakes the device on completion
// - result read left or right justified by the justify select bit
// - software result writes stored right justified; left mode reads shifted by four
// - converter runs only while the module enable bit is one
// - start by software go, selected trigger, or continuous retrigger
// - on completion old result copies to previous when prev select is one
// - completion clears go unless repeat, sets done, computation_status_bit, updates accumulator
// - error computed every conversion, or every second with double sampling
// - threshold flag sets when the computed error meets the comparison
// - filter and threshold work happens after the done flag is set
// - go cleared mid-conversion stores partial result, unconverted bits copy last bit
// - a terminated conversion still gets filter and threshold computation
// - reset restores all registers, turns converter off, aborts conversion
// - conversion in sleep only with the rc oscillator selected
// - with rc clock, start delayed by one extra instruction cycle
// - sleep completion without interrupt powers down, enable bit stays set
// - trigger in sleep with rc clock converts and sets done flag
// - trigger in sleep without rc clock stays pending until sleep ends
// - rising edge of selected trigger sets go
// - conversion clock is system clock over 2*(n+1) or the rc oscillator
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // axi4-lite write channels
   input  wire logic [7:0]        awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read channels
   input  wire logic [7:0]        araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // analog side and system
   input  wire logic              cmp_in,
   input  wire logic              rc_tick,
   input  wire logic [7:0]        trig_in,
   input  wire logic              sleep_in,
   output logic [RES_W-1:0]       sar_code,
   output logic                   analog_on,
   output logic                   conv_irq,
   output logic                   wake_req
);
   acs_state_type       state;
   logic [7:0]          ctrl;
   logic [DIV_W-1:0]    clkdiv;
   logic [TRG_W-1:0]    trig_sel;
   logic [RES_W-1:0]    result;
   logic [RES_W-1:0]    prev;
   logic [2:0]          status;
   logic [ACC_W-1:0]    acc;
   logic [RES_W:0]      err;
   logic [RES_W-1:0]    setpt;
   logic [RES_W-1:0]    thresh;
   logic                aw_got;
   logic                w_got;
   logic [7:0]          aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic [7:0]          div_cnt;
   logic [3:0]          bit_idx;
   logic [2:0]          wait_cnt;
   logic                pair;
   logic                trig_d;
   logic                pwr_down;
   logic                wr_en;
   logic [31:0]         wmask;
   logic [31:0]         rd_val;
   logic                rd_ok;
   logic                div_tick;
   logic                ctick;
   logic                trig_rise;
   logic                sw_go_set;
   logic                sw_go_clr;
   logic                complete;
   logic                aborting;
   logic [RES_W-1:0]    next_result;
   logic [RES_W:0]      next_err;

   // sequence controls
   wire go   = ctrl[CTRL_GO];
   wire on   = ctrl[CTRL_ON];
   wire cs   = ctrl[CTRL_CS];
   wire rpt  = ctrl[CTRL_REPEAT];

   function automatic logic [15:0] fmt(input logic [RES_W-1:0] v, input logic justify_select);
      fmt = justify_select ? {4'h0, v} : {v, 4'h0};
   endfunction : fmt

   // replace unconverted bits by the last decided bit
   function automatic logic [RES_W-1:0] fill(input logic [RES_W-1:0] v,
                                             input logic [3:0] idx);
      logic [RES_W-1:0] r;
      logic             last;
      r    = v;
      last = (idx == 4'hB) ? 1'b0 : v[idx+4'h1];
      for (int i = 0; i < RES_W; i++) begin
         if (i <= int'(idx)) begin
            r[i] = last;
         end
      end
      fill = r;
   endfunction : fill

   // write path: byte lanes merge into the current value
   assign wr_en = aw_got && w_got && !bvalid;
   assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (wr_en ? aw_addr : araddr)
         ADDR_CTRL:   rd_val = {24'h0, ctrl};
         ADDR_CLKDIV: rd_val = {25'h0, clkdiv};
         ADDR_TRIG:   rd_val = {29'h0, trig_sel};
         ADDR_RESULT: rd_val = {16'h0, fmt(result, ctrl[CTRL_JUST])};
         ADDR_PREV:   rd_val = {16'h0, fmt(prev, ctrl[CTRL_JUST])};
         ADDR_STATUS: rd_val = {29'h0, status};
         ADDR_ACC:    rd_val = {16'h0, acc};
         ADDR_ERR:    rd_val = {{19{err[RES_W]}}, err};
         ADDR_SETPT:  rd_val = {20'h0, setpt};
         ADDR_THRESH: rd_val = {20'h0, thresh};
         default:     rd_ok  = 1'b0;
      endcase
   end

   wire [31:0] wv     = (rd_val & ~wmask) | (w_data & wmask);
   wire        wr_ctl = wr_en && aw_addr == ADDR_CTRL && w_strb[0];
   wire        wr_st  = wr_en && aw_addr == ADDR_STATUS && w_strb[0];

   // axi write address and data are taken independently
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awready <= 1'b0;
         aw_got  <= 1'b0;
         aw_addr <= 8'h00;
      end else if (awready && awvalid) begin
         awready <= 1'b0;
         aw_got  <= 1'b1;
         aw_addr <= awaddr;
      end else if (wr_en) begin
         aw_got  <= 1'b0;
      end else if (!aw_got && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wready <= 1'b0;
         w_got  <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (wready && wvalid) begin
         wready <= 1'b0;
         w_got  <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (wr_en) begin
         w_got  <= 1'b0;
      end else if (!w_got && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OK;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read is refused while a write is being applied, so the mux stays shared
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OK;
      end else if (arready && arvalid && !wr_en) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_val;
         rresp   <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clkdiv   <= '0;
         trig_sel <= '0;
         setpt    <= RES_RST;
         thresh   <= RES_RST;
      end else if (wr_en) begin
         if (aw_addr == ADDR_CLKDIV) clkdiv   <= wv[DIV_W-1:0];
         if (aw_addr == ADDR_TRIG)   trig_sel <= wv[TRG_W-1:0];
         if (aw_addr == ADDR_SETPT)  setpt    <= wv[RES_W-1:0];
         if (aw_addr == ADDR_THRESH) thresh   <= wv[RES_W-1:0];
      end
   end

   // conversion clock: divided system clock or rc ticks
   always_ff @(posedge clk) begin
      if (!rst_n || !on || cs || state == ST_IDLE || div_tick) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign div_tick = on && !cs && !sleep_in && div_cnt == {clkdiv, 1'b1};
   assign ctick    = cs ? rc_tick : div_tick;

   // go bit: hardware set wins over software clear
   assign trig_rise = trig_in[trig_sel] && !trig_d;
   assign sw_go_set = wr_ctl && wv[CTRL_GO] && on;
   assign sw_go_clr = wr_ctl && !wv[CTRL_GO];
   assign aborting  = state == ST_CONV && !go;
   assign complete  = state == ST_CONV && on && ((ctick && bit_idx == 4'h0) || !go);

   always_ff @(posedge clk) begin
      if (!rst_n) trig_d <= 1'b0;
      else        trig_d <= trig_in[trig_sel];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= CTRL_RST;
      end else begin
         if (wr_ctl) ctrl[7:1] <= wv[7:1];
         if (!on) begin
            ctrl[CTRL_GO] <= 1'b0;
         end else if (trig_rise || sw_go_set) begin
            ctrl[CTRL_GO] <= 1'b1;
         end else if (sw_go_clr || (complete && !rpt)) begin
            ctrl[CTRL_GO] <= 1'b0;
         end
      end
   end

   // sequencer
   always_ff @(posedge clk) begin
      if (!rst_n || !on) begin
         state    <= ST_IDLE;
         bit_idx  <= 4'hB;
         wait_cnt <= 3'h0;
         sar_code <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               bit_idx  <= 4'hB;
               wait_cnt <= 3'h0;
               if (go && !(sleep_in && !cs)) begin
                  state    <= cs ? ST_WAIT : ST_CONV;
                  sar_code <= 12'h800;
               end
            end
            ST_WAIT: begin
               wait_cnt <= wait_cnt + 3'h1;
               if (!go) state <= ST_IDLE;
               else if (wait_cnt == 3'(INSTR_CYC - 1)) state <= ST_CONV;
            end
            ST_CONV: begin
               if (complete) begin
                  state <= ST_CALC;
               end else if (ctick) begin
                  sar_code[bit_idx]         <= cmp_in;
                  sar_code[bit_idx - 4'h1] <= 1'b1;
                  bit_idx                   <= bit_idx - 4'h1;
               end
            end
            ST_CALC: state <= ST_IDLE;
         endcase
      end
   end

   // result of this conversion, partial when go was cleared
   always_comb begin
      next_result = sar_code;
      next_result[bit_idx] = cmp_in;
      if (aborting) next_result = fill(sar_code, bit_idx);
   end
   assign next_err = {1'b0, result} - {1'b0, setpt};

   // result, previous result and accumulator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result <= RES_RST;
         prev   <= RES_RST;
         acc    <= '0;
      end else if (complete) begin
         if (ctrl[CTRL_PREV]) prev <= result;
         result <= next_result;
         acc    <= acc + ACC_W'(next_result);
      end else if (wr_en && aw_addr == ADDR_RESULT) begin
         result <= wv[RES_W-1:0];
      end
   end

   // error and threshold run one cycle after completion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err  <= '0;
         pair <= 1'b0;
      end else if (state == ST_CALC) begin
         pair <= ctrl[CTRL_DOUBLE] && !pair;
         if (!ctrl[CTRL_DOUBLE] || pair) err <= next_err;
      end
   end
   wire calc_now = state == ST_CALC && (!ctrl[CTRL_DOUBLE] || pair);
   wire thr_hit  = calc_now && $signed(next_err) > $signed({1'b0, thresh});

   // status flags; a hardware set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= 3'h0;
      end else begin
         if (complete) status[STAT_DONE] <= 1'b1;
         else if (wr_st && wv[STAT_DONE]) status[STAT_DONE] <= 1'b0;
         if (thr_hit) status[STAT_THR] <= 1'b1;
         else if (wr_st && wv[STAT_THR]) status[STAT_THR] <= 1'b0;
         if (complete) status[STAT_COMPUTATION_STATUS_BIT] <= 1'b1;
         else if (wr_st && wv[STAT_COMPUTATION_STATUS_BIT]) status[STAT_COMPUTATION_STATUS_BIT] <= 1'b0;
      end
   end

   // sleep power-down keeps the enable bit set
   always_ff @(posedge clk) begin
      if (!rst_n || !sleep_in || !on) begin
         pwr_down <= 1'b0;
      end else if (complete && !ctrl[CTRL_IE]) begin
         pwr_down <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         analog_on <= 1'b0;
         conv_irq  <= 1'b0;
         wake_req  <= 1'b0;
      end else begin
         analog_on <= on && !pwr_down && !(complete && sleep_in && !ctrl[CTRL_IE]);
         conv_irq  <= status[STAT_DONE] && ctrl[CTRL_IE];
         wake_req  <= complete && sleep_in && ctrl[CTRL_IE];
      end
   end

   // checks
   a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n)
      complete |=> status[STAT_DONE]) else $error("done flag missed");
   a_done_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      status[STAT_DONE] && !wr_st |=> status[STAT_DONE]) else $error("done lost");
   a_wake_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      complete && sleep_in && ctrl[CTRL_IE] |=> wake_req ##1 conv_irq)
      else $error("no wake");
   a_go_clears: assert property (@(posedge clk) disable iff (!rst_n)
      complete && !rpt && !trig_rise && !sw_go_set && on |=> !go) else $error("go kept");
   a_off_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !on |=> state == ST_IDLE && !go) else $error("runs while off");
   a_rc_delay: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_IDLE && go && cs && on && !$past(trig_rise) |=> state == ST_WAIT)
      else $error("rc delay skipped");
   a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
      sleep_in && !cs && state == ST_IDLE |=> state == ST_IDLE) else $error("start in sleep");
   a_calc_after: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_CALC |-> $past(complete)) else $error("calc early");
   a_busy_go: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_CONV && on && !complete |-> go) else $error("go low while busy");
endmodule : acs_sequencer
`default_nettype wire

// File: bench/acs_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb_top;
   import acs_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} acs_rexp_type;
   logic        clk;
   logic        rst_n;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        cmp_in;
   logic        rc_tick;
   logic [7:0]  trig_in;
   logic        sleep_in;
   logic [11:0] sar_code;
   logic        analog_on;
   logic        conv_irq;
   logic        wake_req;
   integer       seed = 38;
   int           failures = 0;
   int           check_count = 0;
   logic [11:0]  target;
   logic [11:0]  prev;
   logic [11:0]  sp;
   logic [12:0]  e;
   logic [15:0]  acc;
   logic [31:0]  last_rd;
   acs_rexp_type rq[$];
   logic [1:0]   bq[$];
   bit           wq[$];

   acs_sequencer DUT (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cmp_in(cmp_in), .rc_tick(rc_tick), .trig_in(trig_in), .sleep_in(sleep_in),
      .sar_code(sar_code), .analog_on(analog_on), .conv_irq(conv_irq), .wake_req(wake_req));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // comparator model: input sits at target, so a full conversion settles on target
   always @(posedge clk) begin
      cmp_in  <= (sar_code <= target);
      rc_tick <= (($random(seed) & 3) == 0);
   end

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_resp

   always @(posedge clk) begin
      acs_rexp_type x;
      if (rst_n && rvalid && rready && rq.size() > 0) begin
         x = rq.pop_front();
         cmp_resp("rresp", x.r, rresp);
         if (x.m != 0)
            cmp_word("rdata", x.d & x.m, rdata & x.m);
      end
      if (rst_n && bvalid && bready && bq.size() > 0)
         cmp_resp("bresp", bq.pop_front(), bresp);
      if (rst_n && wake_req === 1'b1) begin
         cmp_word("wake_req expected", 32'h1, {31'h0, wq.size() != 0});
         if (wq.size() != 0)
            wq.delete(0);
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      bq.push_back(r);
      do begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rq.push_back('{d, m, r});
      do begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      last_rd = rdata;
      rready  <= 1'b0;
   endtask : rd

   task automatic wait_idle();
      do
         rd(ADDR_CTRL, 32'h0, 32'h0, RESP_OK);
      while (last_rd[0] !== 1'b0);
   endtask : wait_idle

   // edge detection needs a few cycles before go can be polled
   task automatic pulse(input int k);
      @(posedge clk);
      trig_in[k] <= 1'b1;
      @(posedge clk);
      trig_in[k] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse

   task automatic convert(input logic [7:0] ctl, input int src);
      target = 12'($random(seed));
      if (src < 0)
         wr(ADDR_CTRL, {24'h0, ctl | 8'h01}, RESP_OK);
      else
         pulse(src);
      rd(ADDR_CTRL, 32'h1, 32'h1, RESP_OK);
      wait_idle();
      acc = acc + 16'(target);
      rd(ADDR_STATUS, 32'h5, 32'h5, RESP_OK);
   endtask : convert

   task automatic conclude();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      {cmp_in, rc_tick, trig_in, sleep_in} = '0;
      wstrb = 4'hF;
      target = 12'h000;
      acc = 16'h0000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, {24'h0, CTRL_RST}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_STATUS, 32'h0, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_RESULT, {20'h0, RES_RST}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_ACC, 32'h0, 32'hFFFFFFFF, RESP_OK);
      rd(8'h28, 32'h0, 32'hFFFFFFFF, RESP_ERR);
      wr(8'h2C, 32'hFFFF, RESP_ERR);
      wr(ADDR_CTRL, 32'h03, RESP_OK);
      rd(ADDR_CTRL, 32'h02, 32'hFF, RESP_OK);
      wr(ADDR_CLKDIV, 32'h3, RESP_OK);
      wr(ADDR_CTRL, 32'h2A, RESP_OK);
      convert(8'h2A, -1);
      prev = target;
      rd(ADDR_RESULT, {20'h0, target}, 32'hFFFFFFFF, RESP_OK);
      cmp_word("conv_irq", 32'h0, {31'h0, conv_irq});
      rd(ADDR_ACC, {16'h0, acc}, 32'hFFFF, RESP_OK);
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      rd(ADDR_STATUS, 32'h0, 32'h7, RESP_OK);
      sp = 12'($random(seed));
      wr(ADDR_SETPT, {20'h0, sp}, RESP_OK);
      wr(ADDR_THRESH, 32'h0, RESP_OK);
      wr(ADDR_CTRL, 32'h22, RESP_OK);
      convert(8'h22, -1);
      rd(ADDR_RESULT, {16'h0, target, 4'h0}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_PREV, {16'h0, prev, 4'h0}, 32'hFFFFFFFF, RESP_OK);
      e = {1'b0, target} - {1'b0, sp};
      rd(ADDR_ERR, {{19{e[12]}}, e}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_STATUS, {30'h1, $signed(e) > 0, 1'b1}, 32'h7, RESP_OK);
      rd(ADDR_ACC, {16'h0, acc}, 32'hFFFF, RESP_OK);
      wr(ADDR_RESULT, 32'hABC, RESP_OK);
      rd(ADDR_RESULT, 32'hABC0, 32'hFFFFFFFF, RESP_OK);
      wr(ADDR_CTRL, 32'h2A, RESP_OK);
      rd(ADDR_RESULT, 32'h0ABC, 32'hFFFFFFFF, RESP_OK);
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_TRIG, k, RESP_OK);
         wr(ADDR_STATUS, 32'h7, RESP_OK);
         convert(8'h2A, k);
         rd(ADDR_RESULT, {20'h0, target}, 32'hFFFFFFFF, RESP_OK);
      end
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      target = 12'hFFF;
      wr(ADDR_CTRL, 32'h2B, RESP_OK);
      repeat (30) @(posedge clk);
      wr(ADDR_CTRL, 32'h2A, RESP_OK);
      wait_idle();
      rd(ADDR_RESULT, 32'hFFF, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_STATUS, 32'h5, 32'h5, RESP_OK);
      e = 13'h0FFF - {1'b0, sp};
      rd(ADDR_ERR, {{19{e[12]}}, e}, 32'hFFFFFFFF, RESP_OK);
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      wr(ADDR_CTRL, 32'h3B, RESP_OK);
      do
         rd(ADDR_STATUS, 32'h0, 32'h0, RESP_OK);
      while (last_rd[0] !== 1'b1);
      rd(ADDR_CTRL, 32'h3B, 32'hFF, RESP_OK);
      wr(ADDR_CTRL, 32'h2A, RESP_OK);
      wait_idle();
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      wr(ADDR_TRIG, 32'h0, RESP_OK);
      sleep_in <= 1'b1;
      pulse(0);
      repeat (300) @(posedge clk);
      rd(ADDR_STATUS, 32'h0, 32'h1, RESP_OK);
      sleep_in <= 1'b0;
      wait_idle();
      rd(ADDR_STATUS, 32'h1, 32'h1, RESP_OK);
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      wr(ADDR_CTRL, 32'hAE, RESP_OK);
      wq.push_back(1'b1);
      sleep_in <= 1'b1;
      pulse(0);
      wait_idle();
      cmp_word("wake pending", 32'h0, wq.size());
      cmp_word("conv_irq", 32'h1, {31'h0, conv_irq});
      rd(ADDR_STATUS, 32'h1, 32'h1, RESP_OK);
      sleep_in <= 1'b0;
      wr(ADDR_STATUS, 32'h7, RESP_OK);
      wr(ADDR_CTRL, 32'h2E, RESP_OK);
      sleep_in <= 1'b1;
      pulse(0);
      wait_idle();
      cmp_word("analog_on", 32'h0, {31'h0, analog_on});
      rd(ADDR_CTRL, 32'h2E, 32'hFF, RESP_OK);
      sleep_in <= 1'b0;
      repeat (3) @(posedge clk);
      cmp_word("analog_on", 32'h1, {31'h0, analog_on});
      // double sampling with the previous copy off: error only every second result
      wr(ADDR_CTRL, 32'h4A, RESP_OK);
      rd(ADDR_PREV, 32'h0, 32'h0, RESP_OK);
      prev = last_rd[11:0];
      rd(ADDR_ERR, 32'h0, 32'h0, RESP_OK);
      e = last_rd[12:0];
      convert(8'h4A, -1);
      rd(ADDR_ERR, {{19{e[12]}}, e}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_PREV, {20'h0, prev}, 32'hFFFFFFFF, RESP_OK);
      convert(8'h4A, -1);
      e = {1'b0, target} - {1'b0, sp};
      rd(ADDR_ERR, {{19{e[12]}}, e}, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_PREV, {20'h0, prev}, 32'hFFFFFFFF, RESP_OK);
      // reset in mid-conversion must leave nothing running
      wr(ADDR_CTRL, 32'h2B, RESP_OK);
      repeat (20) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OK);
      rd(ADDR_STATUS, 32'h0, 32'hFFFFFFFF, RESP_OK);
      cmp_word("analog_on", 32'h0, {31'h0, analog_on});
      conclude();
   end
endmodule : acs_sequencer_tb_top
`default_nettype wire
